// ==== logic/nvm_save_load_map.vh ====
`ifndef NVM_SAVE_LOAD_MAP_VH
`define NVM_SAVE_LOAD_MAP_VH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_WRITE_GUARD 8'h13
`define CMD_SAVE_ALL 8'h15
`define CMD_LOAD_ALL 8'h16
`define CMD_RISE_COMP 8'h1C
`define CMD_FILTER_CFG 8'h1D
`define CMD_GAIN_CTRL 8'h1E
`define CMD_NVM_CONTROL 8'h06
`define CMD_COMM_STATUS 8'h7E
// ----------------------------------------------------------------
// guard values and field positions
// ----------------------------------------------------------------
`define GUARD_BLOCK 8'h00
`define GUARD_ALLOW 8'h63
`define CML_CRC_BIT 4
`define NVC_CRC_PROT_BIT 0
`define GAIN_CTRL_MASK 8'h3F
`define RC_EN_BIT 15
`define RC_DEC_HI 14
`define RC_DEC_LO 9
`define RC_INC_HI 8
`define RC_INC_LO 6
`define RC_CEIL_HI 5
`define RC_CEIL_LO 0
`define FC_TAU_HI 15
`define FC_TAU_LO 14
`define FC_FILT_EN_BIT 13
`define FC_CMP_EN_BIT 12
`define FC_HOLD_HI 11
`define FC_HOLD_LO 6
`define FC_THR_HI 5
`define FC_THR_LO 0
`define GC_TONLY_BIT 5
`define GC_BW_BIT 4
`define GC_GAIN_HI 3
`define GC_GAIN_LO 0
// ----------------------------------------------------------------
// reset values and store layout
// ----------------------------------------------------------------
`define RST_GUARD 8'h00
`define RST_WORD16 16'h0000
`define RST_BYTE 8'h00
`define NVM_WORDS 4
`define NVM_IDX_W 2
`define NVM_CRC_IDX 3
`define NVM_LAST_IDX 2'h2
`define CRC_INIT 8'hFF
`define CRC_POLY 8'h07
`endif

// ==== logic/crc8_step.v ====
`default_nettype none
// one byte of crc-8, msb first
module crc8_step (
	// running value and data in
	input wire [7:0] crcIn,
	input wire [7:0] dataIn,
	// updated value
	output wire [7:0] crcOut
);
	`include "nvm_save_load_map.vh"

	// ----------------------------------------------------------------
	// bitwise fold
	// ----------------------------------------------------------------
	function [7:0] fold;
		input [7:0] c;
		input [7:0] d;
		integer i;
		reg [7:0] v;
		begin
			v = c ^ d;
			for (i = 0; i < 8; i = i + 1)
			begin
				if (v[7])
					v = {v[6:0], 1'b0} ^ `CRC_POLY;
				else
					v = {v[6:0], 1'b0};
			end
			fold = v;
		end
	endfunction

	assign crcOut = fold(crcIn, dataIn);
endmodule // crc8_step
`default_nettype wire

// ==== logic/nvm_save_load_regs.v ====
`default_nettype none
`include "nvm_save_load_map.vh"
// Notes on behaviour
// - write guard 0x00 blocks store writes, 0x63 allows them
// - save command 15h copies page-0 registers and their crc to store
// - save and load commands carry no data byte
// - load command 16h restores page-0 registers and computes crc
// - load crc mismatch sets status bit 4 at 7Eh
// - nvm control bit 0 picks the crc fault action
// - protection bit 1 stops power on crc fault, 0 keeps running
// - after reset the same load runs automatically
// - load is ignored while output power is on
// - rise compensation bit 15 enables upward-transition compensation
// - bits 14:9 give decay step interval, 50 ns units
// - bits 8:6 give reference steps per compensation increment
// - bits 5:0 cap the compensation, 6.25 mV units
// - filter bits 15:14 select reference filter time constant
// - filter bit 13 enables reference output filter
// - filter bit 12 enables reference versus filtered comparator
// - filter bits 11:6 give hold time, 50 ns units
// - filter bits 5:0 fall threshold, only with filter enabled
// - gain bit 5 enables transient-only load-line mode
// - gain bit 4 selects loop bandwidth, only in transient mode
// - gain bits 3:0 select load-line ratio
module nvm_save_load_regs (
	// clock and reset
	input wire clock,
	input wire rstn,
	// command port from the bus engine
	input wire cmdWrite,
	input wire cmdRead,
	input wire [7:0] cmdCode,
	input wire cmdHasData,
	input wire [15:0] cmdData,
	// status of the power stage
	input wire powerOnPin,
	// read answer
	output reg [15:0] readData,
	output reg readValid,
	output reg busy,
	// settings to the control loops
	output reg slopeCompEnable,
	output reg [5:0] slopeCompDecayInterval,
	output reg [2:0] slopeCompRiseStepCount,
	output reg [5:0] slopeCompCeiling,
	output reg [1:0] refFilterTauSelect,
	output reg refFilterEnable,
	output reg refCompareEnable,
	output reg [5:0] slopeCompHoldTime,
	output reg [5:0] slopeCompFallThreshold,
	output reg [5:0] fallThresholdActive,
	output reg transientOnlyLoadlineEnable,
	output reg transientLoadlineBandwidth,
	output reg transientBandwidthActive,
	output reg [3:0] loadlineGainSelect,
	// fault handling
	output reg crcFault,
	output reg shutdownReq
);
	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	// sequencer states
	localparam ST_IDLE = 2'b00;
	localparam ST_SAVE = 2'b01;
	localparam ST_LOAD = 2'b10;
	localparam ST_CHECK = 2'b11;
	// last page-0 word before the crc slot
	localparam [1:0] LAST_WORD = `NVM_LAST_IDX;

	reg [1:0] state_reg;
	reg [1:0] idx_reg;
	reg [7:0] crc_reg;
	reg [7:0] guard_reg;
	reg [15:0] riseComp_reg;
	reg [15:0] filterCfg_reg;
	reg [7:0] gainCtrl_reg;
	reg [7:0] nvmControl_reg;
	reg [7:0] commStatus_reg;
	// nvm image: page-0 words, then the crc
	reg [15:0] store [0:`NVM_WORDS-1];
	reg powerSync1_reg;
	reg powerSync2_reg;
	wire [7:0] crcA;
	wire [7:0] crcB;
	reg [15:0] curWord;
	reg [15:0] curReg;

	// ----------------------------------------------------------------
	// crc over a 16-bit word, high byte first
	// ----------------------------------------------------------------
	// two byte steps in series give one word per clock
	crc8_step crcHigh (
		.crcIn(crc_reg),
		.dataIn(curWord[15:8]),
		.crcOut(crcA)
	);
	crc8_step crcLow (
		.crcIn(crcA),
		.dataIn(curWord[7:0]),
		.crcOut(crcB)
	);

	// data-free command of one code: save and load carry no byte
	function bareCommand;
		input w;
		input hasData;
		input [7:0] code;
		input [7:0] want;
		begin
			bareCommand = w && !hasData && (code == want);
		end
	endfunction

	// word of the page-0 set at an index
	function [15:0] pageWord;
		input [1:0] i;
		input [15:0] a;
		input [15:0] b;
		input [7:0] c;
		begin
			case (i)
				2'b00: pageWord = a;
				2'b01: pageWord = b;
				default: pageWord = {8'h00, c};
			endcase
		end
	endfunction

	// saving hashes live registers, loading hashes the store
	always @*
	begin
		curReg = pageWord(idx_reg, riseComp_reg, filterCfg_reg,
			gainCtrl_reg);
		if (state_reg == ST_SAVE)
			curWord = curReg;
		else
			curWord = store[idx_reg];
	end

	// ----------------------------------------------------------------
	// power-on pin synchroniser
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			powerSync1_reg <= 1'b0;
			powerSync2_reg <= 1'b0;
		end
		else
		begin
			// only the second stage is read by logic
			powerSync1_reg <= powerOnPin;
			powerSync2_reg <= powerSync1_reg;
		end
	end

	// ----------------------------------------------------------------
	// register writes, save and load sequencer
	// ----------------------------------------------------------------
	// store is not reset: it models non-volatile content
	always @(posedge clock)
	begin
		if (state_reg == ST_SAVE)
		begin
			store[idx_reg] <= curReg;
			if (idx_reg == LAST_WORD)
				store[`NVM_CRC_IDX] <= {8'h00, crcB};
		end
	end

	always @(posedge clock)
	begin
		if (!rstn)
		begin
			state_reg <= ST_LOAD;
			idx_reg <= 2'b00;
			crc_reg <= `CRC_INIT;
			guard_reg <= `RST_GUARD;
			riseComp_reg <= `RST_WORD16;
			filterCfg_reg <= `RST_WORD16;
			gainCtrl_reg <= `RST_BYTE;
			nvmControl_reg <= `RST_BYTE;
			commStatus_reg <= `RST_BYTE;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					// idle rearms the walk for the next command
					idx_reg <= 2'b00;
					crc_reg <= `CRC_INIT;
					// save only through an open guard, no data byte
					if (bareCommand(cmdWrite, cmdHasData, cmdCode,
						`CMD_SAVE_ALL) && guard_reg == `GUARD_ALLOW)
						state_reg <= ST_SAVE;
					// load refused while the output delivers power
					if (bareCommand(cmdWrite, cmdHasData, cmdCode,
						`CMD_LOAD_ALL) && !powerSync2_reg)
						state_reg <= ST_LOAD;
					if (cmdWrite && cmdHasData)
					begin
						case (cmdCode)
							`CMD_WRITE_GUARD: guard_reg <= cmdData[7:0];
							`CMD_RISE_COMP: riseComp_reg <= cmdData;
							`CMD_FILTER_CFG: filterCfg_reg <= cmdData;
							`CMD_GAIN_CTRL:
								gainCtrl_reg <= cmdData[7:0]
									& `GAIN_CTRL_MASK;
							`CMD_NVM_CONTROL: nvmControl_reg <= cmdData[7:0];
							// write of ones clears status bits
							`CMD_COMM_STATUS:
								commStatus_reg <= commStatus_reg
									& ~cmdData[7:0];
							default: ;
						endcase
					end
				end
				// crc runs alongside the copy, stored with the last word
				ST_SAVE:
				begin
					crc_reg <= crcB;
					idx_reg <= idx_reg + 2'b01;
					if (idx_reg == LAST_WORD)
						state_reg <= ST_IDLE;
				end
				// same crc walk as save, so like is compared with like
				ST_LOAD:
				begin
					crc_reg <= crcB;
					idx_reg <= idx_reg + 2'b01;
					case (idx_reg)
						2'b00: riseComp_reg <= store[idx_reg];
						2'b01: filterCfg_reg <= store[idx_reg];
						default:
							gainCtrl_reg <= store[idx_reg][7:0]
								& `GAIN_CTRL_MASK;
					endcase
					if (idx_reg == LAST_WORD)
						state_reg <= ST_CHECK;
				end
				// a mismatch only flags; the stop decision sits downstream
				ST_CHECK:
				begin
					if (crc_reg != store[`NVM_CRC_IDX][7:0])
						commStatus_reg[`CML_CRC_BIT] <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			readData <= `RST_WORD16;
			readValid <= 1'b0;
		end
		else
		begin
			// unmapped codes read zero; reads still work while busy
			readValid <= cmdRead;
			case (cmdCode)
				`CMD_WRITE_GUARD: readData <= {8'h00, guard_reg};
				`CMD_RISE_COMP: readData <= riseComp_reg;
				`CMD_FILTER_CFG: readData <= filterCfg_reg;
				`CMD_GAIN_CTRL: readData <= {8'h00, gainCtrl_reg};
				`CMD_NVM_CONTROL: readData <= {8'h00, nvmControl_reg};
				`CMD_COMM_STATUS: readData <= {8'h00, commStatus_reg};
				default: readData <= `RST_WORD16;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// setting outputs, registered from the bank
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			busy <= 1'b1;
			slopeCompEnable <= 1'b0;
			slopeCompDecayInterval <= 6'h00;
			slopeCompRiseStepCount <= 3'h0;
			slopeCompCeiling <= 6'h00;
			refFilterTauSelect <= 2'h0;
			refFilterEnable <= 1'b0;
			refCompareEnable <= 1'b0;
			slopeCompHoldTime <= 6'h00;
			slopeCompFallThreshold <= 6'h00;
			fallThresholdActive <= 6'h00;
			transientOnlyLoadlineEnable <= 1'b0;
			transientLoadlineBandwidth <= 1'b0;
			transientBandwidthActive <= 1'b0;
			loadlineGainSelect <= 4'h0;
			crcFault <= 1'b0;
			shutdownReq <= 1'b0;
		end
		else
		begin
			// outputs trail the bank by one edge, straight from flops
			busy <= (state_reg != ST_IDLE);
			slopeCompEnable <= riseComp_reg[`RC_EN_BIT];
			slopeCompDecayInterval <=
				riseComp_reg[`RC_DEC_HI:`RC_DEC_LO];
			slopeCompRiseStepCount <=
				riseComp_reg[`RC_INC_HI:`RC_INC_LO];
			slopeCompCeiling <=
				riseComp_reg[`RC_CEIL_HI:`RC_CEIL_LO];
			refFilterTauSelect <=
				filterCfg_reg[`FC_TAU_HI:`FC_TAU_LO];
			refFilterEnable <= filterCfg_reg[`FC_FILT_EN_BIT];
			refCompareEnable <= filterCfg_reg[`FC_CMP_EN_BIT];
			slopeCompHoldTime <=
				filterCfg_reg[`FC_HOLD_HI:`FC_HOLD_LO];
			slopeCompFallThreshold <= filterCfg_reg[`FC_THR_HI:`FC_THR_LO];
			// threshold gated off when filter disabled
			fallThresholdActive <= filterCfg_reg[`FC_FILT_EN_BIT]
				? filterCfg_reg[`FC_THR_HI:`FC_THR_LO] : 6'h00;
			transientOnlyLoadlineEnable <=
				gainCtrl_reg[`GC_TONLY_BIT];
			transientLoadlineBandwidth <= gainCtrl_reg[`GC_BW_BIT];
			// bandwidth only counts in transient-only mode
			transientBandwidthActive <= gainCtrl_reg[`GC_TONLY_BIT]
				& gainCtrl_reg[`GC_BW_BIT];
			loadlineGainSelect <=
				gainCtrl_reg[`GC_GAIN_HI:`GC_GAIN_LO];
			crcFault <= commStatus_reg[`CML_CRC_BIT];
			// shutdown only when protection is on
			shutdownReq <= commStatus_reg[`CML_CRC_BIT]
				& nvmControl_reg[`NVC_CRC_PROT_BIT];
		end
	end
endmodule // nvm_save_load_regs
`default_nettype wire

// ==== dv/nvm_regs_checker.sv ====
`default_nettype none
`include "nvm_save_load_map.vh"
// ----
// port checks
// ----
module nvm_regs_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// requests
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic [7:0] cmdCode,
	input wire logic cmdHasData,
	input wire logic [15:0] cmdData,
	input wire logic powerOnPin,
	// answers and settings
	input wire logic [15:0] readData,
	input wire logic readValid,
	input wire logic busy,
	input wire logic slopeCompEnable,
	input wire logic [5:0] slopeCompDecayInterval,
	input wire logic [2:0] slopeCompRiseStepCount,
	input wire logic [5:0] slopeCompCeiling,
	input wire logic refFilterEnable,
	input wire logic [1:0] refFilterTauSelect,
	input wire logic refCompareEnable,
	input wire logic [5:0] slopeCompHoldTime,
	input wire logic [5:0] slopeCompFallThreshold,
	input wire logic [5:0] fallThresholdActive,
	input wire logic transientOnlyLoadlineEnable,
	input wire logic transientLoadlineBandwidth,
	input wire logic transientBandwidthActive,
	input wire logic [3:0] loadlineGainSelect,
	input wire logic crcFault,
	input wire logic shutdownReq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// writes land in the register, fields follow one edge later
	gain_write_a: assert property (cmdWrite && cmdHasData && !busy
		&& cmdCode == `CMD_GAIN_CTRL |-> ##2 {10'h000,
		transientOnlyLoadlineEnable, transientLoadlineBandwidth,
		loadlineGainSelect} == ($past(cmdData, 2) & 16'h003F))
		else $error("gain fields wrong");
	rise_write_a: assert property (cmdWrite && cmdHasData && !busy
		&& cmdCode == `CMD_RISE_COMP |-> ##2 {slopeCompEnable,
		slopeCompDecayInterval, slopeCompRiseStepCount,
		slopeCompCeiling} == $past(cmdData, 2))
		else $error("rise fields wrong");
	reserved_zero_a: assert property (readValid
		&& $past(cmdCode) == `CMD_GAIN_CTRL |-> readData[15:6] == 10'h000)
		else $error("reserved bits read set");
	thr_gate_a: assert property (fallThresholdActive ==
		(refFilterEnable ? slopeCompFallThreshold : 6'h00))
		else $error("threshold not gated");
	bw_gate_a: assert property (transientBandwidthActive ==
		(transientLoadlineBandwidth && transientOnlyLoadlineEnable))
		else $error("bandwidth not gated");
	shut_cause_a: assert property (shutdownReq |-> crcFault)
		else $error("shutdown without fault");
	filter_write_a: assert property (cmdWrite && cmdHasData && !busy
		&& cmdCode == `CMD_FILTER_CFG |-> ##2 {refFilterTauSelect,
		refFilterEnable, refCompareEnable, slopeCompHoldTime,
		slopeCompFallThreshold} == $past(cmdData, 2))
		else $error("filter fields wrong");
	// the pin reaches the sequencer through two flops
	load_ignored_a: assert property (cmdWrite && !cmdHasData && !busy
		&& cmdCode == `CMD_LOAD_ALL && $past(powerOnPin, 2)
		|=> !busy [*3])
		else $error("load ran with power on");
	load_runs_a: assert property (cmdWrite && !cmdHasData && !busy
		&& cmdCode == `CMD_LOAD_ALL && !$past(powerOnPin, 2)
		|-> ##[1:3] busy)
		else $error("load did not start");
	boot_load_a: assert property (!$past(rstn) |-> busy ##1 busy)
		else $error("no load after reset");
endmodule // nvm_regs_checker
bind nvm_save_load_regs nvm_regs_checker i_chk (.clock(clock), .rstn(rstn),
	.cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
	.cmdHasData(cmdHasData), .cmdData(cmdData), .powerOnPin(powerOnPin),
	.readData(readData), .readValid(readValid), .busy(busy),
	.slopeCompEnable(slopeCompEnable),
	.slopeCompDecayInterval(slopeCompDecayInterval),
	.slopeCompRiseStepCount(slopeCompRiseStepCount),
	.slopeCompCeiling(slopeCompCeiling),
	.refFilterEnable(refFilterEnable),
	.refFilterTauSelect(refFilterTauSelect),
	.refCompareEnable(refCompareEnable),
	.slopeCompHoldTime(slopeCompHoldTime),
	.slopeCompFallThreshold(slopeCompFallThreshold),
	.fallThresholdActive(fallThresholdActive),
	.transientOnlyLoadlineEnable(transientOnlyLoadlineEnable),
	.transientLoadlineBandwidth(transientLoadlineBandwidth),
	.transientBandwidthActive(transientBandwidthActive),
	.loadlineGainSelect(loadlineGainSelect),
	.crcFault(crcFault), .shutdownReq(shutdownReq));
`default_nettype wire

// ==== dv/pmbus_host_model.sv ====
`default_nettype none
// ----
// host side of the command port
// ----
module pmbus_host_model (
	// clock
	input wire logic clock,
	// answers
	input wire logic [15:0] readData,
	input wire logic readValid,
	// requests
	output var logic cmdWrite,
	output var logic cmdRead,
	output var logic [7:0] cmdCode,
	output var logic cmdHasData,
	output var logic [15:0] cmdData
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial
	begin
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = 8'h00;
		cmdHasData = 1'b0;
		cmdData = 16'h0000;
	end
	// one write, or a bare command code when hasData is low
	task automatic send(input logic [7:0] code, input logic hasData,
		input logic [15:0] data);
		@(negedge clock);
		cmdCode = code;
		cmdHasData = hasData;
		cmdData = data;
		cmdWrite = 1'b1;
		@(negedge clock);
		cmdWrite = 1'b0;
		cmdData = ~data; // released data must not look held
	endtask
	// answer stands for the cycle after the request
	task automatic fetch(input logic [7:0] code, output logic [15:0] data,
		output logic ok);
		@(negedge clock);
		cmdCode = code;
		cmdRead = 1'b1;
		@(negedge clock);
		cmdRead = 1'b0;
		ok = readValid;
		data = readData;
	endtask
endmodule // pmbus_host_model
`default_nettype wire

// ==== dv/nvm_save_load_regs_tb.sv ====
`default_nettype none
`include "nvm_save_load_map.vh"
module nvm_save_load_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, rstn, powerOnPin, cmdWrite, cmdRead, cmdHasData;
	logic readValid, busy, crcFault, shutdownReq;
	logic [7:0] cmdCode;
	logic [15:0] cmdData, readData;
	int failures = 0;
	int checks_done = 0;
	int i;
	pmbus_host_model i_host (.clock(clock), .readData(readData),
		.readValid(readValid), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
		.cmdCode(cmdCode), .cmdHasData(cmdHasData), .cmdData(cmdData));
	nvm_save_load_regs i_dut (.clock(clock), .rstn(rstn),
		.cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
		.cmdHasData(cmdHasData), .cmdData(cmdData),
		.powerOnPin(powerOnPin), .readData(readData),
		.readValid(readValid), .busy(busy), .slopeCompEnable(),
		.slopeCompDecayInterval(), .slopeCompRiseStepCount(),
		.slopeCompCeiling(), .refFilterTauSelect(), .refFilterEnable(),
		.refCompareEnable(), .slopeCompHoldTime(),
		.slopeCompFallThreshold(), .fallThresholdActive(),
		.transientOnlyLoadlineEnable(), .transientLoadlineBandwidth(),
		.transientBandwidthActive(), .loadlineGainSelect(),
		.crcFault(crcFault), .shutdownReq(shutdownReq));
	// ----
	// helpers
	// ----
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		i_host.fetch(code, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(d, exp);
	endtask
	// a sequence shows only through busy, so look for it briefly
	task automatic busyRise(input logic want);
		logic seen;
		seen = 1'b0;
		repeat (4)
		begin
			@(negedge clock);
			if (busy === 1'b1)
				seen = 1'b1;
		end
		chk({15'h0000, seen}, {15'h0000, want});
	endtask
	task automatic waitIdle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 40)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= 40)
		begin
			failures++;
			$display("[ERR] %0t busy stuck", $time);
			conclude();
		end
	endtask
	task automatic resetPulse();
		rstn = 1'b0;
		repeat (3) @(negedge clock);
		rstn = 1'b1;
	endtask
	// ----
	// clock and sequence
	// ----
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial
	begin
		powerOnPin = 1'b0;
		// blank nvm image so the boot load starts from known words
		for (i = 0; i < `NVM_WORDS; i++)
			i_dut.store[i] = 16'h0000;
		resetPulse();
		waitIdle();
		chk({15'h0000, shutdownReq}, 16'h0000);
		// boot crc of the blank image may fail; clear the flag
		i_host.send(`CMD_COMM_STATUS, 1'b1, 16'h00FF);
		rd(`CMD_COMM_STATUS, 16'h0000);
		rd(`CMD_WRITE_GUARD, 16'h0000);
		rd(8'h50, 16'h0000);
		for (i = 0; i < 16; i++)
		begin
			i_host.send(`CMD_GAIN_CTRL, 1'b1, {10'h3C0, i[1:0], i[3:0]});
			rd(`CMD_GAIN_CTRL, {10'h000, i[1:0], i[3:0]});
		end
		for (i = 0; i < 4; i++)
		begin
			i_host.send(`CMD_FILTER_CFG, 1'b1, {i[1:0], 14'h2A95});
			rd(`CMD_FILTER_CFG, {i[1:0], 14'h2A95});
		end
		i_host.send(`CMD_FILTER_CFG, 1'b1, 16'h1FFF);
		rd(`CMD_FILTER_CFG, 16'h1FFF);
		i_host.send(`CMD_RISE_COMP, 1'b1, 16'hA5C3);
		rd(`CMD_RISE_COMP, 16'hA5C3);
		// guard closed: save has no effect
		i_host.send(`CMD_SAVE_ALL, 1'b0, 16'h0000);
		busyRise(1'b0);
		i_host.send(`CMD_WRITE_GUARD, 1'b1, 16'h0063);
		rd(`CMD_WRITE_GUARD, 16'h0063);
		i_host.send(`CMD_NVM_CONTROL, 1'b1, 16'h0001);
		rd(`CMD_NVM_CONTROL, 16'h0001);
		i_host.send(`CMD_SAVE_ALL, 1'b0, 16'h0000);
		busyRise(1'b1);
		waitIdle();
		i_host.send(`CMD_RISE_COMP, 1'b1, 16'h1234);
		i_host.send(`CMD_LOAD_ALL, 1'b0, 16'h0000);
		busyRise(1'b1);
		waitIdle();
		rd(`CMD_RISE_COMP, 16'hA5C3);
		rd(`CMD_COMM_STATUS, 16'h0000);
		chk({14'h0000, crcFault, shutdownReq}, 16'h0000);
		// spoil the stored crc: load must flag it and, protected, stop
		i_dut.store[`NVM_CRC_IDX] = i_dut.store[`NVM_CRC_IDX] ^ 16'h00FF;
		i_host.send(`CMD_LOAD_ALL, 1'b0, 16'h0000);
		busyRise(1'b1);
		waitIdle();
		rd(`CMD_COMM_STATUS, 16'h0010);
		chk({14'h0000, crcFault, shutdownReq}, 16'h0003);
		// unprotected: the same fault leaves power running
		i_host.send(`CMD_COMM_STATUS, 1'b1, 16'h0010);
		i_host.send(`CMD_NVM_CONTROL, 1'b1, 16'h0000);
		i_host.send(`CMD_LOAD_ALL, 1'b0, 16'h0000);
		busyRise(1'b1);
		waitIdle();
		chk({14'h0000, crcFault, shutdownReq}, 16'h0002);
		rd(`CMD_RISE_COMP, 16'hA5C3);
		i_dut.store[`NVM_CRC_IDX] = i_dut.store[`NVM_CRC_IDX] ^ 16'h00FF;
		// output on: load must be dropped
		powerOnPin = 1'b1;
		i_host.send(`CMD_RISE_COMP, 1'b1, 16'h00FF);
		i_host.send(`CMD_LOAD_ALL, 1'b0, 16'h0000);
		busyRise(1'b0);
		rd(`CMD_RISE_COMP, 16'h00FF);
		powerOnPin = 1'b0;
		@(negedge clock);
		resetPulse();
		waitIdle();
		rd(`CMD_RISE_COMP, 16'hA5C3);
		rd(`CMD_WRITE_GUARD, 16'h0000);
		conclude();
	end
endmodule // nvm_save_load_regs_tb
`default_nettype wire
